// file: design/isam_i2c_status.sv
`timescale 1ns/1ps
module isam_i2c_status
   import isam_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             irq
);
   logic        scl_s1, scl_s2, scl_d;
   logic        sda_s1, sda_s2, sda_d;
   logic        pready_reg, pslverr_reg, irq_reg;
   logic        sda_oe_reg, sda_o_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_next;
   isam_state_t state_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  rx_shift_reg, tx_shift_reg;
   logic [7:0]  tx_holding_reg, rx_holding_reg;
   logic [9:0]  address_ignore_bits_reg, own_reg;
   logic [3:0]  ctrl_reg;
   logic [IRQ_W-1:0] ist_reg, imsk_reg, ev;
   logic ack_result_flag_reg, master_tx_active_reg;
   logic bus_collision_flag_reg, general_call_seen_reg;
   logic ten_bit_match_flag_reg, tx_write_collision_reg;
   logic rx_overflow_flag_reg, data_addr_reg;
   logic stop_seen_reg, start_seen_reg, read_dir_reg;
   logic rx_buffer_full_reg, tx_buffer_full_reg, ack_pend_reg;
   logic [15:0] stat_word;
   logic en, mst, acc, wr_acc, rd_acc, tx_wr, busy, tx_accept;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [7:0] cur_byte;
   logic hit, gc_hit, addr_ok, byte_ev, coll_ev, mtx_ack_ev;
   logic gc_ev, ten_ev, rx_ev, rx_xfer, ov_ev, stx_done;

   function automatic logic reg_hit(input logic [7:0] off);
      return paddr == off;
   endfunction

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq     = irq_reg;
   assign sda_oe  = sda_oe_reg;
   assign sda_o   = sda_o_reg;

   // Pin synchronisers; the second stage and its delayed copy feed logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   assign scl_rise  = scl_s2 & ~scl_d;
   assign scl_fall  = ~scl_s2 & scl_d;
   assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign cur_byte  = {rx_shift_reg[6:0], sda_s2};

   assign en  = ctrl_reg[CTRL_EN];
   assign mst = ctrl_reg[CTRL_MST];
   assign acc    = psel & penable & pready_reg;
   assign wr_acc = acc & pwrite;
   assign rd_acc = acc & ~pwrite;
   assign tx_wr  = wr_acc & reg_hit(TX_OFF);
   assign busy   = master_tx_active_reg | tx_buffer_full_reg;
   assign tx_accept = tx_wr & ~busy & en;

   isam_addr_match u_match (
      .byte_in  (cur_byte),
      .own_addr (own_reg),
      .ignore   (address_ignore_bits_reg),
      .ten_mode (ctrl_reg[CTRL_A10]),
      .second   (state_reg == ST_ADDR2),
      .gc_en    (ctrl_reg[CTRL_GCEN]),
      .hit      (hit),
      .gc_hit   (gc_hit)
   );

   // A 10-bit read header only matches after the full address was seen
   assign byte_ev = en & scl_rise & (cnt_reg == LAST_BIT)
                    & (state_reg inside {ST_ADDR, ST_ADDR2, ST_RX});
   assign addr_ok = byte_ev & (state_reg == ST_ADDR)
                    & (gc_hit | (hit & (~ctrl_reg[CTRL_A10]
                       | ~cur_byte[0] | ten_bit_match_flag_reg)));
   assign gc_ev   = byte_ev & (state_reg == ST_ADDR) & gc_hit;
   assign ten_ev  = byte_ev & (state_reg == ST_ADDR2) & hit;
   assign rx_ev   = byte_ev & (state_reg == ST_RX);
   assign rx_xfer = rx_ev & ~rx_buffer_full_reg;
   assign ov_ev   = rx_ev & rx_buffer_full_reg;
   assign coll_ev = en & scl_rise & (state_reg == ST_MTX)
                    & (cnt_reg < ACK_CNT) & tx_shift_reg[7] & ~sda_s2;
   assign mtx_ack_ev = en & scl_rise & (state_reg == ST_MTX)
                       & (cnt_reg == ACK_CNT);
   assign stx_done = en & scl_rise & (state_reg == ST_STX)
                     & (cnt_reg == ACK_CNT) & ~ack_pend_reg;

   // Byte sequencer for slave receive, slave transmit and master transmit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= ST_IDLE;
         cnt_reg      <= 4'h0;
         rx_shift_reg <= BYTE_RST;
         tx_shift_reg <= BYTE_RST;
      end else if (!en || stop_det) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
      end else if (start_det && state_reg != ST_MTX) begin
         state_reg <= ST_ADDR;
         cnt_reg   <= 4'h0;
      end else if (tx_accept && mst) begin
         state_reg    <= ST_MTX;
         cnt_reg      <= 4'h0;
         tx_shift_reg <= pwdata[7:0];
      end else if (scl_rise) begin
         case (state_reg)
            ST_ADDR, ST_ADDR2, ST_RX: begin
               if (cnt_reg < ACK_CNT) begin
                  cnt_reg      <= cnt_reg + 4'h1;
                  rx_shift_reg <= cur_byte;
               end else begin
                  cnt_reg <= 4'h0;
                  if (state_reg == ST_STX)
                     tx_shift_reg <= tx_holding_reg;
               end
               if (byte_ev && state_reg == ST_ADDR) begin
                  if (!addr_ok)
                     state_reg <= ST_SKIP;
                  else if (gc_hit)
                     state_reg <= ST_RX;
                  else if (cur_byte[0])
                     state_reg <= ST_STX;
                  else if (ctrl_reg[CTRL_A10])
                     state_reg <= ST_ADDR2;
                  else
                     state_reg <= ST_RX;
               end
               if (byte_ev && state_reg == ST_ADDR2)
                  state_reg <= hit ? ST_RX : ST_SKIP;
            end
            ST_STX: begin
               if (cnt_reg < ACK_CNT) begin
                  cnt_reg      <= cnt_reg + 4'h1;
                  tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
               end else begin
                  cnt_reg      <= 4'h0;
                  tx_shift_reg <= tx_holding_reg;
                  if (!ack_pend_reg && sda_s2)
                     state_reg <= ST_SKIP;
               end
            end
            ST_MTX: begin
               if (coll_ev) begin
                  state_reg <= ST_IDLE;
               end else if (cnt_reg < ACK_CNT) begin
                  cnt_reg      <= cnt_reg + 4'h1;
                  tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
               end else begin
                  state_reg <= ST_IDLE;
                  cnt_reg   <= 4'h0;
               end
            end
            default: begin
               cnt_reg <= cnt_reg;
            end
         endcase
      end
   end

   // Slave acknowledge owed at the ninth clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ack_pend_reg <= 1'b0;
      else if (!en || stop_det)
         ack_pend_reg <= 1'b0;
      else if (addr_ok || ten_ev || rx_xfer)
         ack_pend_reg <= 1'b1;
      else if (scl_rise && cnt_reg == ACK_CNT)
         ack_pend_reg <= 1'b0;
   end

   // Open-drain data drive changes after a falling clock edge, or at once on Stop, collision, disable or a master write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_oe_reg <= 1'b0;
         sda_o_reg  <= 1'b0;
      end else if (!en || stop_det || coll_ev) begin
         sda_oe_reg <= 1'b0;
      end else if (tx_accept && mst) begin
         sda_oe_reg <= ~pwdata[7];
      end else if (scl_fall) begin
         if (cnt_reg == ACK_CNT)
            sda_oe_reg <= ack_pend_reg;
         else if (state_reg inside {ST_STX, ST_MTX})
            sda_oe_reg <= ~tx_shift_reg[7];
         else
            sda_oe_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_result_flag_reg  <= 1'b0;
         master_tx_active_reg <= 1'b0;
      end else begin
         if (mtx_ack_ev)
            ack_result_flag_reg <= sda_s2;
         if (tx_accept && mst)
            master_tx_active_reg <= 1'b1;
         else if (mtx_ack_ev || coll_ev || !en || stop_det)
            master_tx_active_reg <= 1'b0;
      end
   end

   // Sticky flags: a hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_collision_flag_reg <= 1'b0;
         tx_write_collision_reg <= 1'b0;
         rx_overflow_flag_reg   <= 1'b0;
      end else begin
         if (coll_ev)
            bus_collision_flag_reg <= 1'b1;
         else if (wr_acc && reg_hit(STAT_OFF) && !pwdata[BCL_B])
            bus_collision_flag_reg <= 1'b0;
         if (tx_wr && busy)
            tx_write_collision_reg <= 1'b1;
         else if (wr_acc && reg_hit(STAT_OFF) && !pwdata[WCOL_B])
            tx_write_collision_reg <= 1'b0;
         if (ov_ev)
            rx_overflow_flag_reg <= 1'b1;
         else if (wr_acc && reg_hit(STAT_OFF) && !pwdata[OV_B])
            rx_overflow_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         general_call_seen_reg  <= 1'b0;
         ten_bit_match_flag_reg <= 1'b0;
         data_addr_reg          <= 1'b0;
         read_dir_reg           <= 1'b0;
         start_seen_reg         <= 1'b0;
         stop_seen_reg          <= 1'b0;
      end else begin
         if (gc_ev)
            general_call_seen_reg <= 1'b1;
         else if (stop_det)
            general_call_seen_reg <= 1'b0;
         if (ten_ev)
            ten_bit_match_flag_reg <= 1'b1;
         else if (stop_det)
            ten_bit_match_flag_reg <= 1'b0;
         if (addr_ok)
            data_addr_reg <= 1'b0;
         else if (rx_ev)
            data_addr_reg <= 1'b1;
         if (addr_ok)
            read_dir_reg <= cur_byte[0];
         if (start_det) begin
            start_seen_reg <= 1'b1;
            stop_seen_reg  <= 1'b0;
         end else if (stop_det) begin
            start_seen_reg <= 1'b0;
            stop_seen_reg  <= 1'b1;
         end
      end
   end

   // Double-buffered receive and single transmit holding register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_holding_reg     <= BYTE_RST;
         rx_buffer_full_reg <= 1'b0;
         tx_holding_reg     <= BYTE_RST;
         tx_buffer_full_reg <= 1'b0;
      end else begin
         if (rx_xfer) begin
            rx_holding_reg     <= cur_byte;
            rx_buffer_full_reg <= 1'b1;
         end else if (rd_acc && reg_hit(RX_OFF)) begin
            rx_buffer_full_reg <= 1'b0;
         end
         if (tx_accept) begin
            tx_holding_reg     <= pwdata[7:0];
            tx_buffer_full_reg <= 1'b1;
         end else if (mtx_ack_ev || stx_done || coll_ev) begin
            tx_buffer_full_reg <= 1'b0;
         end
      end
   end

   // Software configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_ignore_bits_reg <= MASK_RST;
         ctrl_reg                <= CTRL_RST;
         own_reg                 <= OWN_RST;
         imsk_reg                <= IRQ_RST;
      end else if (wr_acc) begin
         if (reg_hit(MASK_OFF))
            address_ignore_bits_reg <= pwdata[9:0];
         if (reg_hit(CTRL_OFF))
            ctrl_reg <= pwdata[3:0];
         if (reg_hit(OWN_OFF))
            own_reg <= pwdata[9:0];
         if (reg_hit(IMSK_OFF))
            imsk_reg <= pwdata[IRQ_W-1:0];
      end
   end

   // Interrupt: sticky events, write one to clear, set wins
   assign ev = {ov_ev, stop_det, coll_ev, mtx_ack_ev, rx_xfer};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_reg <= IRQ_RST;
         irq_reg <= 1'b0;
      end else begin
         if (wr_acc && reg_hit(IST_OFF))
            ist_reg <= (ist_reg & ~pwdata[IRQ_W-1:0]) | ev;
         else
            ist_reg <= ist_reg | ev;
         irq_reg <= |(ist_reg & imsk_reg);
      end
   end

   always_comb begin
      stat_word         = 16'h0000;
      stat_word[ACK_B]  = ack_result_flag_reg;
      stat_word[TRS_B]  = master_tx_active_reg;
      stat_word[BCL_B]  = bus_collision_flag_reg;
      stat_word[GC_B]   = general_call_seen_reg;
      stat_word[A10_B]  = ten_bit_match_flag_reg;
      stat_word[WCOL_B] = tx_write_collision_reg;
      stat_word[OV_B]   = rx_overflow_flag_reg;
      stat_word[DA_B]   = data_addr_reg;
      stat_word[P_B]    = stop_seen_reg;
      stat_word[S_B]    = start_seen_reg;
      stat_word[RW_B]   = read_dir_reg;
      stat_word[RBF_B]  = rx_buffer_full_reg;
      stat_word[TBF_B]  = tx_buffer_full_reg;
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      case (paddr)
         STAT_OFF: rd_next = {16'h0000, stat_word};
         MASK_OFF: rd_next = {22'h000000, address_ignore_bits_reg};
         CTRL_OFF: rd_next = {28'h0000000, ctrl_reg};
         OWN_OFF:  rd_next = {22'h000000, own_reg};
         TX_OFF:   rd_next = {24'h000000, tx_holding_reg};
         RX_OFF:   rd_next = {24'h000000, rx_holding_reg};
         IST_OFF:  rd_next = {27'h0000000, ist_reg};
         IMSK_OFF: rd_next = {27'h0000000, imsk_reg};
         default:  rd_next = 32'h0000_0000;
      endcase
   end

   // APB slave: one access cycle, data and error registered at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready_reg  <= 1'b1;
         pslverr_reg <= (paddr[1:0] != 2'h0) || (paddr > IMSK_OFF);
         prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
      end else begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_mtx_ack;
      mtx_ack_ev ##0 sda_s2;
   endsequence
   sequence s_tx_write;
      psel && penable && pready_reg && pwrite && paddr == TX_OFF;
   endsequence

   property p_ack_nack;
      s_mtx_ack |=> ack_result_flag_reg && !master_tx_active_reg;
   endproperty
   a_ack_nack: assert property (p_ack_nack)
      else $error("nack not reported");

   property p_mtx_start;
      s_tx_write ##0 (!busy && en && mst) |=>
         master_tx_active_reg && tx_buffer_full_reg
         && state_reg == ST_MTX;
   endproperty
   a_mtx_start: assert property (p_mtx_start)
      else $error("master transmit did not start");

   property p_bcl_hold;
      bus_collision_flag_reg && !wr_acc |=> bus_collision_flag_reg;
   endproperty
   a_bcl_hold: assert property (p_bcl_hold)
      else $error("collision flag lost");

   property p_stop_clear;
      stop_det |=> !general_call_seen_reg && !ten_bit_match_flag_reg
         && stop_seen_reg && !start_seen_reg;
   endproperty
   a_stop_clear: assert property (p_stop_clear)
      else $error("stop did not clear call flags");

   property p_wcol;
      s_tx_write ##0 busy |=> tx_write_collision_reg
         && $stable(tx_holding_reg);
   endproperty
   a_wcol: assert property (p_wcol)
      else $error("busy write not rejected");

   property p_overflow;
      ov_ev |=> rx_overflow_flag_reg && $stable(rx_holding_reg);
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow not flagged");

   property p_start_seen;
      start_det |=> start_seen_reg && !stop_seen_reg;
   endproperty
   a_start_seen: assert property (p_start_seen)
      else $error("start indicator wrong");

   property p_rx_full;
      rx_xfer |=> rx_buffer_full_reg && data_addr_reg
         && rx_holding_reg == $past(cur_byte)
         ##1 (irq_reg || !imsk_reg[IRQ_RX]);
   endproperty
   a_rx_full: assert property (p_rx_full)
      else $error("receive transfer not recorded");

   property p_reserved;
      psel && !penable && !pwrite && paddr == STAT_OFF |=>
         prdata_reg[13:11] == 3'h0 && prdata_reg[31:16] == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved status bits not zero");
endmodule

// file: include/isam_pkg.sv
package isam_pkg;
   localparam logic [7:0] STAT_OFF = 8'h00;
   localparam logic [7:0] MASK_OFF = 8'h04;
   localparam logic [7:0] CTRL_OFF = 8'h08;
   localparam logic [7:0] OWN_OFF  = 8'h0c;
   localparam logic [7:0] TX_OFF   = 8'h10;
   localparam logic [7:0] RX_OFF   = 8'h14;
   localparam logic [7:0] IST_OFF  = 8'h18;
   localparam logic [7:0] IMSK_OFF = 8'h1c;
   localparam int ACK_B  = 15;
   localparam int TRS_B  = 14;
   localparam int BCL_B  = 10;
   localparam int GC_B   = 9;
   localparam int A10_B  = 8;
   localparam int WCOL_B = 7;
   localparam int OV_B   = 6;
   localparam int DA_B   = 5;
   localparam int P_B    = 4;
   localparam int S_B    = 3;
   localparam int RW_B   = 2;
   localparam int RBF_B  = 1;
   localparam int TBF_B  = 0;
   localparam int CTRL_EN   = 0;
   localparam int CTRL_MST  = 1;
   localparam int CTRL_A10  = 2;
   localparam int CTRL_GCEN = 3;
   localparam int IRQ_W    = 5;
   localparam int IRQ_RX   = 0;
   localparam int IRQ_MTX  = 1;
   localparam int IRQ_COL  = 2;
   localparam int IRQ_STOP = 3;
   localparam int IRQ_OV   = 4;
   localparam logic [9:0]  MASK_RST = 10'h000;
   localparam logic [3:0]  CTRL_RST = 4'h0;
   localparam logic [9:0]  OWN_RST  = 10'h000;
   localparam logic [7:0]  BYTE_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
   localparam logic [7:0]  GC_ADDR  = 8'h00;
   localparam logic [4:0]  TEN_HDR  = 5'h1e;
   localparam logic [3:0]  ACK_CNT  = 4'h8;
   localparam logic [3:0]  LAST_BIT = 4'h7;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR2, ST_RX, ST_STX, ST_MTX, ST_SKIP
   } isam_state_t;
endpackage

// file: design/isam_addr_match.sv
`timescale 1ns/1ps
module isam_addr_match
   import isam_pkg::*;
(
   input  wire logic [7:0] byte_in,
   input  wire logic [9:0] own_addr,
   input  wire logic [9:0] ignore,
   input  wire logic       ten_mode,
   input  wire logic       second,
   input  wire logic       gc_en,
   output logic            hit,
   output logic            gc_hit
);
   logic h7;
   logic h10a;
   logic h10b;

   // Masked positions drop out of the compare
   assign h7   = ((byte_in[7:1] ^ own_addr[6:0])
                  & ~ignore[6:0]) == 7'h00;
   assign h10a = (byte_in[7:3] == TEN_HDR)
                 && (((byte_in[2:1] ^ own_addr[9:8])
                      & ~ignore[9:8]) == 2'h0);
   assign h10b = ((byte_in ^ own_addr[7:0])
                  & ~ignore[7:0]) == 8'h00;
   assign hit    = second ? h10b : (ten_mode ? h10a : h7);
   assign gc_hit = gc_en & ~second & (byte_in == GC_ADDR);
endmodule

// file: tb/isam_bus_model.sv
`timescale 1ns/1ps
module isam_bus_model (
   output logic      scl,
   output logic      sda_rel,
   input  wire logic sda
);
   // Open-drain far side: a released line floats high by pull-up
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic bit_io(input logic b, output logic s);
      sda_rel = b;
      #100 scl = 1'b1;
      #100 s = sda;
      #100 scl = 1'b0;
      #100;
   endtask
   task automatic start();
      #100 scl = 1'b1;
      #100 sda_rel = 1'b0;
      #100 scl = 1'b0;
      #100;
   endtask
   task automatic stop();
      sda_rel = 1'b0;
      #100 scl = 1'b1;
      #100 sda_rel = 1'b1;
      #100;
   endtask
   // Nine clocks with the far side driving drv, MSB first; q holds the bus
   task automatic xfer(input logic [8:0] drv, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
         bit_io(drv[i], q[i]);
   endtask
   task automatic send_byte(input logic [7:0] d, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], s);
      bit_io(1'b1, nack);
   endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
   import isam_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, scl, sda_rel, sda_o, sda_oe, irq, a;
   wire         sda = sda_rel & ~sda_oe;
   int          n_fail = 0;
   int          compares = 0;
   int          seed = 69;
   logic [33:0] notes[$];
   logic [9:0]  m;
   logic [6:0]  own;
   logic [7:0]  d;
   logic [8:0]  q;
   isam_i2c_status i_isam_i2c_status (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl),
      .sda_i(sda), .sda_o, .sda_oe, .irq);
   isam_bus_model mdl (.scl, .sda_rel, .sda);
   always #25 pclk = ~pclk;
   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [33:0] s, e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [33:0] e);
      notes.push_back(e);
      apb(1'b0, ad, 32'h0);
   endtask
   // Result word is {irq, pslverr, prdata} in the read's access cycle
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
         check($sformatf("reg %h", paddr), {irq, pslverr, prdata},
               notes.pop_front());
   initial begin
      #1000000;
      n_fail++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(STAT_OFF, 34'h0);
      rd(MASK_OFF, 34'h0);
      rd(8'h20, {2'b01, 32'h0});
      m = 10'($random(seed));
      apb(1'b1, MASK_OFF, {22'h3fffff, m});
      rd(MASK_OFF, {24'h0, m});
      own = {4'h5, 3'($random(seed))};
      m = 10'($random(seed)) & 10'h07e;
      apb(1'b1, MASK_OFF, {22'h0, m});
      apb(1'b1, OWN_OFF, {25'h0, own});
      apb(1'b1, IMSK_OFF, 32'h1);
      apb(1'b1, CTRL_OFF, 32'h1);
      mdl.start();
      mdl.send_byte({own ^ (m[6:0] & 7'($random(seed))), 1'b0}, a);
      check("addr ack", {33'h0, a}, 34'h0);
      d = 8'($random(seed));
      mdl.send_byte(d, a);
      check("data ack", {33'h0, a}, 34'h0);
      rd(STAT_OFF, {2'b10, 32'h2a});
      rd(RX_OFF, {2'b10, 24'h0, d});
      rd(STAT_OFF, {2'b10, 32'h28});
      apb(1'b1, IMSK_OFF, 32'h0);
      rd(IST_OFF, 34'h1);
      mdl.send_byte(~d, a);
      mdl.send_byte(d, a);
      check("ovf nack", {33'h0, a}, 34'h1);
      mdl.stop();
      rd(STAT_OFF, 34'h72);
      apb(1'b1, STAT_OFF, 32'h0);
      rd(STAT_OFF, 34'h32);
      apb(1'b1, TX_OFF, 32'h11);
      apb(1'b1, TX_OFF, 32'h22);
      rd(STAT_OFF, 34'hb3);
      rd(IST_OFF, 34'h19);
      apb(1'b1, IST_OFF, 32'h1f);
      rd(IST_OFF, 34'h0);
      mdl.start();
      mdl.send_byte({own ^ 7'h01, 1'b0}, a);
      check("miss nack", {33'h0, a}, 34'h1);
      mdl.stop();
      // Slave transmit drains the byte kept from the accepted first write
      mdl.start();
      mdl.send_byte({own, 1'b1}, a);
      check("read addr ack", {33'h0, a}, 34'h0);
      mdl.xfer(9'h1ff, q);
      check("slave tx data", {25'h0, q}, {25'h0, 8'h11, 1'b1});
      mdl.stop();
      rd(STAT_OFF, 34'h96);
      // Master transmit answered by NACK, then one lost to a collision
      apb(1'b1, CTRL_OFF, 32'h3);
      mdl.start();
      d = 8'($random(seed));
      apb(1'b1, TX_OFF, {24'h0, d});
      rd(STAT_OFF, 34'h408f);
      mdl.xfer(9'h1ff, q);
      check("master tx data", {26'h0, q[8:1]}, {26'h0, d});
      rd(STAT_OFF, 34'h808e);
      apb(1'b1, TX_OFF, 32'hff);
      mdl.xfer(9'h0ff, q);
      mdl.stop();
      rd(STAT_OFF, 34'h8496);
      rd(IST_OFF, 34'he);
      // General call is acknowledged and flagged until the Stop
      apb(1'b1, CTRL_OFF, 32'h9);
      mdl.start();
      mdl.send_byte(8'h00, a);
      check("call ack", {33'h0, a}, 34'h0);
      rd(STAT_OFF, 34'h868a);
      mdl.stop();
      rd(STAT_OFF, 34'h8492);
      check("sda_o", {33'h0, sda_o}, 34'h0);
      repeat (4) @(posedge pclk);
      summarize();
   end
endmodule
